// file: src/smbus_cfg_pkg.sv
// Constants and types shared by the SMBus configuration and status block
package smbus_cfg_pkg;
  // Register address and layout
  localparam logic [7:0] CFG_ADDR = 8'hc1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WR_MASK = 8'hdf;
  localparam int BIT_ON = 7;
  localparam int BIT_INH = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_HOLD = 4;
  localparam int BIT_TOE = 3;
  localparam int BIT_FTE = 2;
  localparam int CS_MSB = 1;
  localparam int CS_LSB = 0;
  // Clock source encodings
  localparam logic [1:0] CS_T0 = 2'h0;
  localparam logic [1:0] CS_T1 = 2'h1;
  localparam logic [1:0] CS_T2H = 2'h2;
  localparam logic [1:0] CS_T2L = 2'h3;
  // SDA timing in system clocks
  localparam logic [3:0] SETUP_NORM = 4'h1;
  localparam logic [3:0] SETUP_EXT = 4'hb;
  localparam logic [3:0] HOLD_NORM = 4'h3;
  localparam logic [3:0] HOLD_EXT = 4'hc;
  // Bus-free detection: more than this many source periods
  localparam logic [3:0] FREE_PERIODS = 4'ha;
  // Overflow ticks per SCL phase; two ticks guarantee one whole period
  localparam logic [3:0] LOW_TICKS = 4'h2;
  localparam logic [3:0] HIGH_TICKS = 4'h2;
  // Software-side SCL low timeout
  localparam int SCL_TIMEOUT_MS = 25;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LOW = 2'b01,
    M_HIGH = 2'b11
  } master_state_t;
endpackage

// file: src/smbus_config_control.sv
// SMBus configuration register, bus monitor, SCL pacing and SDA timing
`timescale 1ns/1ns
`default_nettype none
module smbus_config_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Timer overflow pulses and timeout timer control
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic t2h_ovf,
  input wire logic t2l_ovf,
  input wire logic timer_split_mode,
  output logic timer_reload_high,
  output logic timer_reload_low,
  // Serial clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // Serial data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Byte engine side
  input wire logic master_clock_run,
  input wire logic sda_low_req,
  input wire logic addr_ack_req,
  output logic addr_ack_grant,
  input wire logic slave_event,
  input wire logic master_event,
  output logic event_irq,
  // Bus condition pulses
  output logic bus_start,
  output logic bus_stop,
  output logic bus_free
);

  function automatic logic [3:0] sat_inc4(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [7:0] rdata_r;
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_d_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_d_r;
  logic [3:0] free_cnt_r;
  logic [3:0] free_cnt_nxt;
  logic inh_act_r;
  logic irq_r;
  logic reload_high_r;
  logic reload_low_r;
  logic start_r;
  logic stop_r;
  logic free_r;
  logic [3:0] hold_cnt_r;
  logic [3:0] setup_cnt_r;
  logic sda_drive_r;
  logic sda_drive_nxt;
  smbus_cfg_pkg::master_state_t state_r;
  smbus_cfg_pkg::master_state_t state_nxt;
  logic [3:0] tick_cnt_r;
  logic [3:0] tick_cnt_nxt;
  logic scl_drive_r;
  logic scl_drive_nxt;

  // Configuration fields
  wire on = cfg_r[smbus_cfg_pkg::BIT_ON];
  wire inh = cfg_r[smbus_cfg_pkg::BIT_INH];
  wire ext_hold = cfg_r[smbus_cfg_pkg::BIT_HOLD];
  wire toe = cfg_r[smbus_cfg_pkg::BIT_TOE];
  wire fte = cfg_r[smbus_cfg_pkg::BIT_FTE];
  wire [1:0] cs = cfg_r[smbus_cfg_pkg::CS_MSB:smbus_cfg_pkg::CS_LSB];

  // Register decode
  wire cfg_hit = (sfr_addr == smbus_cfg_pkg::CFG_ADDR);
  wire cfg_we = sfr_wr & cfg_hit;
  wire [7:0] busy_bits = 8'(busy_r) << smbus_cfg_pkg::BIT_BUSY;
  wire [7:0] cfg_view = (cfg_r & smbus_cfg_pkg::CFG_WR_MASK) | busy_bits;

  // Pacing overflow selection
  wire tick = (cs == smbus_cfg_pkg::CS_T0) ? t0_ovf :
              (cs == smbus_cfg_pkg::CS_T1) ? t1_ovf :
              (cs == smbus_cfg_pkg::CS_T2H) ? t2h_ovf : t2l_ovf;

  // Bus conditions on the synchronised lines, only while enabled
  wire scl_fall = scl_d_r & ~scl_s2_r;
  wire lines_high = scl_s2_r & sda_s2_r;
  wire start_det = on & scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_det = on & scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  wire free_det = on & fte & lines_high & tick & (free_cnt_r == smbus_cfg_pkg::FREE_PERIODS);

  // SDA timing limits
  wire [3:0] hold_min = ext_hold ? smbus_cfg_pkg::HOLD_EXT : smbus_cfg_pkg::HOLD_NORM;
  wire [3:0] setup_min = ext_hold ? smbus_cfg_pkg::SETUP_EXT : smbus_cfg_pkg::SETUP_NORM;
  wire hold_ok = (hold_cnt_r >= hold_min);
  wire setup_ok = (setup_cnt_r >= setup_min);
  // Our own SCL pull restarts the hold count, before the late synced fall is seen
  wire scl_grab = scl_drive_nxt & ~scl_drive_r;

  assign cfg_nxt = cfg_we ? (sfr_wdata & smbus_cfg_pkg::CFG_WR_MASK) : cfg_r;

  always_comb begin
    busy_nxt = busy_r;
    if (!on) begin
      busy_nxt = 1'b0;
    end else if (stop_det || free_det) begin
      busy_nxt = 1'b0;
    end else if (start_det) begin
      busy_nxt = 1'b1;
    end
  end

  // Counts source periods with both lines high; stops once past the limit
  always_comb begin
    free_cnt_nxt = free_cnt_r;
    if (!on || !fte || !lines_high) begin
      free_cnt_nxt = 4'h0;
    end else if (tick && free_cnt_r <= smbus_cfg_pkg::FREE_PERIODS) begin
      free_cnt_nxt = sat_inc4(free_cnt_r);
    end
  end

  // New SDA level is applied only after the hold time has passed
  always_comb begin
    sda_drive_nxt = sda_drive_r;
    if (!on) begin
      sda_drive_nxt = 1'b0;
    end else if (hold_ok) begin
      sda_drive_nxt = sda_low_req;
    end
  end

  // Master SCL pacing
  always_comb begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    scl_drive_nxt = scl_drive_r;
    case (state_r)
      smbus_cfg_pkg::M_IDLE: begin
        scl_drive_nxt = 1'b0;
        tick_cnt_nxt = 4'h0;
        if (on && master_clock_run) begin
          state_nxt = smbus_cfg_pkg::M_LOW;
          scl_drive_nxt = 1'b1;
        end
      end
      smbus_cfg_pkg::M_LOW: begin
        if (tick) begin
          tick_cnt_nxt = sat_inc4(tick_cnt_r);
        end
        if (tick_cnt_r >= smbus_cfg_pkg::LOW_TICKS && setup_ok) begin
          state_nxt = smbus_cfg_pkg::M_HIGH;
          scl_drive_nxt = 1'b0;
          tick_cnt_nxt = 4'h0;
        end
      end
      smbus_cfg_pkg::M_HIGH: begin
        if (!scl_s2_r) begin
          tick_cnt_nxt = 4'h0;
        end else if (tick) begin
          tick_cnt_nxt = sat_inc4(tick_cnt_r);
        end
        if (scl_d_r && !scl_s2_r) begin
          // Another device pulled SCL low: follow it into the low phase
          state_nxt = smbus_cfg_pkg::M_LOW;
          scl_drive_nxt = 1'b1;
          tick_cnt_nxt = 4'h0;
        end else if (tick_cnt_r >= smbus_cfg_pkg::HIGH_TICKS) begin
          tick_cnt_nxt = 4'h0;
          if (master_clock_run) begin
            state_nxt = smbus_cfg_pkg::M_LOW;
            scl_drive_nxt = 1'b1;
          end else begin
            state_nxt = smbus_cfg_pkg::M_IDLE;
          end
        end
      end
      default: begin
        state_nxt = smbus_cfg_pkg::M_IDLE;
        scl_drive_nxt = 1'b0;
        tick_cnt_nxt = 4'h0;
      end
    endcase
    if (!on) begin
      state_nxt = smbus_cfg_pkg::M_IDLE;
      scl_drive_nxt = 1'b0;
      tick_cnt_nxt = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_r <= smbus_cfg_pkg::CFG_RESET;
      busy_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      busy_r <= busy_nxt;
      rdata_r <= (sfr_rd && cfg_hit) ? cfg_view : 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      free_cnt_r <= 4'h0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      free_r <= 1'b0;
    end else begin
      free_cnt_r <= free_cnt_nxt;
      start_r <= start_det;
      stop_r <= stop_det;
      free_r <= free_det;
    end
  end

  // Inhibit armed at a START; releasing the bit acts at once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      inh_act_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      inh_act_r <= inh & (inh_act_r | start_det);
      irq_r <= on & (master_event | (slave_event & ~inh_act_r));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reload_high_r <= 1'b0;
      reload_low_r <= 1'b0;
    end else begin
      reload_high_r <= on & toe & scl_s2_r;
      reload_low_r <= on & toe & scl_s2_r & ~timer_split_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_cnt_r <= 4'hf;
      setup_cnt_r <= 4'hf;
      sda_drive_r <= 1'b0;
    end else begin
      hold_cnt_r <= (scl_fall || scl_grab) ? 4'h0 : sat_inc4(hold_cnt_r);
      setup_cnt_r <= (sda_drive_nxt != sda_drive_r) ? 4'h0 : sat_inc4(setup_cnt_r);
      sda_drive_r <= sda_drive_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= smbus_cfg_pkg::M_IDLE;
      tick_cnt_r <= 4'h0;
      scl_drive_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      scl_drive_r <= scl_drive_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign timer_reload_high = reload_high_r;
  assign timer_reload_low = reload_low_r;
  assign scl_out = 1'b0;
  assign scl_oe_n = ~scl_drive_r;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_drive_r;
  assign addr_ack_grant = on & addr_ack_req & ~inh_act_r;
  assign event_irq = irq_r;
  assign bus_start = start_r;
  assign bus_stop = stop_r;
  assign bus_free = free_r;

endmodule
`default_nettype wire

// file: testbench/smbus_bus_partner.sv
// Other bus parties: wired-AND lines with pull-ups
`timescale 1ns/1ns
`default_nettype none
module smbus_bus_partner (
  // Device line enables, low while driving
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // Other parties pulling the lines low
  input wire logic oth_scl_low,
  input wire logic oth_sda_low,
  // Wire levels seen by everyone
  output wire logic scl_in,
  output wire logic sda_in
);
  assign scl_in = scl_oe_n & ~oth_scl_low;
  assign sda_in = sda_oe_n & ~oth_sda_low;
endmodule
`default_nettype wire

// file: testbench/smbus_config_control_tb.sv
// Self-checking bench for the SMBus configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); num_errors++; end end
module smbus_config_control_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, timer_split_mode = 1'b0, master_clock_run = 1'b0;
  logic sda_low_req = 1'b0, addr_ack_req = 1'b0, slave_event = 1'b0, master_event = 1'b0;
  logic oth_scl_low = 1'b0, oth_sda_low = 1'b0, seen_start = 1'b0, seen_free = 1'b0;
  logic seen_stop = 1'b0;
  logic [3:0] ovf = 4'h0;
  wire logic t0_ovf = ovf[0], t1_ovf = ovf[1], t2h_ovf = ovf[2], t2l_ovf = ovf[3];
  logic timer_reload_high, timer_reload_low, scl_in, scl_out, scl_oe_n, sda_in, sda_out;
  logic sda_oe_n, addr_ack_grant, event_irq, bus_start, bus_stop, bus_free, prev, started;
  int num_errors = 0, samples_checked = 0, len, lo_min, hi_min, sda_at;
  localparam logic [7:0] A = smbus_cfg_pkg::CFG_ADDR;
  smbus_config_control smbus_config_control_inst (.*);
  smbus_bus_partner smbus_bus_partner_inst (.*);
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (bus_start) seen_start = 1'b1;
    if (bus_free) seen_free = 1'b1;
    if (bus_stop) seen_stop = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    `CHK(nm, ex, sfr_rdata)
  endtask
  task automatic tick(input int i);
    ovf[i] = 1'b1;
    step(1);
    ovf = 4'h0;
    step(1);
  endtask
  // Half of the 800 ns link period per line change
  task automatic bus(input logic scl, input logic sda);
    oth_scl_low = ~scl;
    oth_sda_low = ~sda;
    step(4);
  endtask
  task automatic ev(input logic s, input logic m, input logic ex, input string nm);
    slave_event = s;
    master_event = m;
    step(1);
    slave_event = 1'b0;
    master_event = 1'b0;
    `CHK(nm, ex, event_irq)
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    step(16);
    reset = 1'b0;
    rd(A, 8'h00, "reset_value");
    wr(A, 8'hff);
    rd(A, 8'hdf, "busy_ro");
    wr(8'hc2, 8'h00);
    rd(A, 8'hdf, "unmapped_wr");
    rd(8'hc2, 8'h00, "unmapped_rd");
    wr(A, 8'h00);
    bus(1, 0);
    bus(1, 1);
    `CHK("off_start", 1'b0, seen_start)
    wr(A, 8'h80);
    bus(1, 0);
    step(4);
    `CHK("start", 1'b1, seen_start)
    rd(A, 8'ha0, "busy_set");
    bus(1, 1);
    step(4);
    rd(A, 8'h80, "busy_stop");
    `CHK("stop", 1'b1, seen_stop)
    `CHK("lines_out", 2'b00, {scl_out, sda_out})
    for (int cs = 0; cs < 4; cs++) begin
      wr(A, 8'h84 | 8'(cs));
      bus(1, 0);
      bus(0, 0);
      bus(0, 1);
      bus(1, 1);
      seen_free = 1'b0;
      repeat (12) tick((cs + 1) % 4);
      repeat (10) tick(cs);
      `CHK("free_early", 1'b0, seen_free)
      tick(cs);
      step(2);
      `CHK("free_late", 1'b1, seen_free)
      rd(A, 8'h84 | 8'(cs), "free_busy");
    end
    wr(A, 8'h88);
    step(4);
    // Software side: the timeout timer is reloaded while SCL is high, counts while low
    `CHK("reload", 2'b11, {timer_reload_high, timer_reload_low})
    timer_split_mode = 1'b1;
    step(2);
    `CHK("split", 2'b10, {timer_reload_high, timer_reload_low})
    bus(0, 1);
    `CHK("scl_low", 2'b00, {timer_reload_high, timer_reload_low})
    bus(1, 1);
    timer_split_mode = 1'b0;
    wr(A, 8'h80);
    addr_ack_req = 1'b1;
    ev(1, 0, 1'b1, "irq_slave");
    wr(A, 8'hc0);
    ev(1, 0, 1'b1, "irq_before_start");
    `CHK("grant_before", 1'b1, addr_ack_grant)
    bus(1, 0);
    step(4);
    ev(1, 0, 1'b0, "irq_inhibit");
    `CHK("grant_inhibit", 1'b0, addr_ack_grant)
    ev(0, 1, 1'b1, "irq_master");
    bus(1, 1);
    addr_ack_req = 1'b0;
    for (int h = 0; h < 2; h++) begin
      wr(A, h ? 8'h90 : 8'h80);
      master_clock_run = 1'b1;
      {prev, started, len, lo_min, hi_min, sda_at} = {2'b10, 32'd0, 32'd999, 32'd999, 32'd0};
      for (int c = 0; c < 300; c++) begin
        ovf[0] = (c % 20 == 0);
        step(1);
        if (!scl_oe_n) sda_low_req = 1'b1;
        if (sda_low_req && sda_oe_n && sda_at < 99) sda_at++;
        if (scl_oe_n !== prev) begin
          if (prev && started && len < hi_min) hi_min = len;
          if (!prev && len < lo_min) lo_min = len;
          started = started | !prev;
          len = 0;
        end
        prev = scl_oe_n;
        len++;
      end
      `CHK("scl_low_min", 1'b1, lo_min >= 20 && lo_min < 999)
      `CHK("scl_high_min", 1'b1, hi_min >= 20 && hi_min < 999)
      `CHK("sda_hold", 1'b1, sda_at >= (h ? 12 : 3) && sda_at < 99)
      master_clock_run = 1'b0;
      ovf = 4'h0;
      step(80);
      sda_low_req = 1'b0;
      step(20);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: testbench/smbus_config_monitor.sv
// Port-level checker for the SMBus configuration block
`timescale 1ns/1ns
`default_nettype none
module smbus_config_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Timer and line control
  input wire logic timer_split_mode,
  input wire logic timer_reload_high,
  input wire logic timer_reload_low,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // Engine side and bus pulses
  input wire logic master_clock_run,
  input wire logic sda_low_req,
  input wire logic addr_ack_req,
  input wire logic addr_ack_grant,
  input wire logic slave_event,
  input wire logic master_event,
  input wire logic event_irq,
  input wire logic bus_start,
  input wire logic bus_stop
);
  logic [7:0] shadow_r;
  wire logic hit = sfr_addr == smbus_cfg_pkg::CFG_ADDR;
  // Mirror of the writable fields
  always_ff @(posedge sys_clk) begin
    if (reset) shadow_r <= 8'h00;
    else if (sfr_wr && hit) shadow_r <= sfr_wdata & smbus_cfg_pkg::CFG_WR_MASK;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence read_hit;
    sfr_rd && hit;
  endsequence
  chk_read_back: assert property (read_hit |=> (sfr_rdata & 8'hdf) == $past(shadow_r))
    else $error("read data differs from written fields");
  chk_read_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data not zero without a read");
  chk_off_quiet: assert property (!shadow_r[7] && !$past(shadow_r[7], 3) |->
    scl_oe_n && sda_oe_n && !bus_start && !bus_stop)
    else $error("disabled interface is active");
  chk_ack_grant: assert property (addr_ack_grant |-> shadow_r[7] && addr_ack_req)
    else $error("address ack without cause");
  chk_reload_cause: assert property (timer_reload_high |-> $past(shadow_r[7] && shadow_r[3]))
    else $error("reload without timeout enable");
  chk_split_high: assert property (timer_reload_low |->
    timer_reload_high && !$past(timer_split_mode))
    else $error("low byte reloaded in split mode");
  chk_master_irq: assert property (master_event && shadow_r[7] |=> event_irq)
    else $error("master event lost");
  chk_irq_cause: assert property (event_irq |-> $past(master_event || slave_event))
    else $error("event interrupt without event");
  chk_scl_cause: assert property ($fell(scl_oe_n) |-> $past(master_clock_run && shadow_r[7]))
    else $error("clock driven low without master run");
  chk_sda_cause: assert property ($fell(sda_oe_n) |-> $past(sda_low_req && shadow_r[7]))
    else $error("data driven low without request");
endmodule
bind smbus_config_control smbus_config_monitor smbus_config_monitor_inst (.*);
`default_nettype wire
